//--- ivf_defines.vh
/*
 * constants for the input over-voltage fault response block:
 * command codes, register reset values, field positions and encodings.
 * assumes it is included by every design file that needs them.
 */
`ifndef IVF_DEFINES_VH
`define IVF_DEFINES_VH

// ----------------------------------------------------------------
// register command codes, reset values and unknown-code read value
// ----------------------------------------------------------------
`define IVF_CMD_THR     8'h55
`define IVF_CMD_ACT     8'h56
`define IVF_THR_RST     16'h7bff
`define IVF_ACT_RST     8'h80
`define IVF_RD_NONE     8'hff

// ----------------------------------------------------------------
// action byte fields
// ----------------------------------------------------------------
`define IVF_RSP_HI      7
`define IVF_RSP_LO      6
`define IVF_RTY_HI      5
`define IVF_RTY_LO      3
`define IVF_DLY_HI      2
`define IVF_DLY_LO      0
`define IVF_RSP_IGNORE  2'b00
`define IVF_RSP_CONT    2'b01
`define IVF_RSP_DISR    2'b10
`define IVF_RSP_LATCH   2'b11
`define IVF_RTY_NONE    3'b000
`define IVF_RTY_FOREVER 3'b111

// ----------------------------------------------------------------
// linear word format and bus constants
// ----------------------------------------------------------------
`define IVF_LIN_ESGN    15
`define IVF_LIN_EHI     14
`define IVF_LIN_ELO     11
`define IVF_LIN_MHI     10
`define IVF_LIN_MLO     0
`define IVF_SMB_ADDR    7'h40
`define IVF_BIT_LAST    4'd7
`define IVF_BYTE_BITS   4'd8

`endif

//--- ivf_smb_slave.v
/*
 * byte-level serial management bus slave: start/stop detection,
 * address match, write bytes out, read bytes in from the owner.
 * assumes scl and sda arrive from pins, asynchronous to clock_i,
 * and that the bus clock is much slower than clock_i.
 */
`timescale 1ns/1ps
`include "ivf_defines.vh"

module ivf_smb_slave #(
	parameter [6:0] ADDR = `IVF_SMB_ADDR
) (
	// clock and reset
	input  wire       clock_i,
	input  wire       srst_i,
	// bus pins
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       sda_o,
	output reg        sda_oe_n_o,
	// received bytes
	output reg        rx_valid_o,
	output reg        rx_first_o,
	output reg  [7:0] rx_data_o,
	// transmitted bytes
	output reg  [3:0] tx_idx_o,
	input  wire [7:0] tx_data_i
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_ADDR = 3'd1;
	localparam [2:0] S_AACK = 3'd2;
	localparam [2:0] S_WR   = 3'd3;
	localparam [2:0] S_WACK = 3'd4;
	localparam [2:0] S_RD   = 3'd5;
	localparam [2:0] S_RACK = 3'd6;

	reg  [2:0] state;     // bus position
	reg  [3:0] bitcnt;    // bits in current byte
	reg  [7:0] sh;        // shift register
	reg        rw;        // read direction
	reg        nack;      // master refused more data
	reg  [3:0] widx;      // write byte index
	reg        scl_m;     // first sync stage
	reg        scl_s;     // second sync stage
	reg        scl_d;     // for edge detect
	reg        sda_m;
	reg        sda_s;
	reg        sda_d;

	// open drain: only ever pull low
	assign sda_o = 1'b0;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// first stage feeds only the second one
	always @(posedge clock_i) begin
		if (srst_i) begin
			{scl_m, scl_s, scl_d} <= 3'b111;
			{sda_m, sda_s, sda_d} <= 3'b111;
		end else begin
			{scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
		end
	end

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
	wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	// ----------------------------------------------------------------
	// byte engine
	// ----------------------------------------------------------------
	// sda changes only after scl falls, so sync lag is harmless
	always @(posedge clock_i) begin
		if (srst_i) begin
			state      <= S_IDLE;
			bitcnt     <= 4'd0;
			sh         <= 8'h00;
			rw         <= 1'b0;
			nack       <= 1'b1;
			widx       <= 4'd0;
			sda_oe_n_o <= 1'b1;
			rx_valid_o <= 1'b0;
			rx_first_o <= 1'b0;
			rx_data_o  <= 8'h00;
			tx_idx_o   <= 4'd0;
		end else begin
			rx_valid_o <= 1'b0;
			if (bus_start) begin
				// repeated start also lands here
				state      <= S_ADDR;
				bitcnt     <= 4'd0;
				sda_oe_n_o <= 1'b1;
			end else if (bus_stop) begin
				state      <= S_IDLE;
				sda_oe_n_o <= 1'b1;
			end else if (scl_rise) begin
				case (state)
					S_ADDR, S_WR: begin
						sh     <= {sh[6:0], sda_s};
						bitcnt <= bitcnt + 4'd1;
					end
					S_RACK:  nack <= sda_s;
					default: nack <= nack;
				endcase
			end else if (scl_fall) begin
				case (state)
					S_ADDR: if (bitcnt == `IVF_BYTE_BITS) begin
						if (sh[7:1] == ADDR) begin
							sda_oe_n_o <= 1'b0;
							rw         <= sh[0];
							widx       <= 4'd0;
							tx_idx_o   <= 4'd0;
							state      <= S_AACK;
						end else begin
							state <= S_IDLE;
						end
					end
					S_AACK: begin
						bitcnt <= 4'd0;
						if (rw) begin
							sh         <= tx_data_i;
							sda_oe_n_o <= tx_data_i[7];
							state      <= S_RD;
						end else begin
							sda_oe_n_o <= 1'b1;
							state      <= S_WR;
						end
					end
					S_WR: if (bitcnt == `IVF_BYTE_BITS) begin
						rx_data_o  <= sh;
						rx_first_o <= (widx == 4'd0);
						rx_valid_o <= 1'b1;
						sda_oe_n_o <= 1'b0;
						state      <= S_WACK;
					end
					S_WACK: begin
						sda_oe_n_o <= 1'b1;
						bitcnt     <= 4'd0;
						widx       <= (widx == 4'hf) ? widx : widx + 4'd1;
						state      <= S_WR;
					end
					S_RD: begin
						bitcnt <= bitcnt + 4'd1;
						if (bitcnt == `IVF_BIT_LAST) begin
							sda_oe_n_o <= 1'b1;
							tx_idx_o   <= tx_idx_o + 4'd1;
							state      <= S_RACK;
						end else begin
							sh         <= {sh[6:0], 1'b0};
							sda_oe_n_o <= sh[6];
						end
					end
					S_RACK: begin
						if (nack) begin
							state <= S_IDLE;
						end else begin
							sh         <= tx_data_i;
							sda_oe_n_o <= tx_data_i[7];
							bitcnt     <= 4'd0;
							state      <= S_RD;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

endmodule

//--- ivf_fault_top.v
/*
 * input over-voltage fault response: threshold and action registers
 * reached over the management bus, comparison of the measured input
 * against the threshold, and the ignore / delay / shutdown / retry /
 * latch-off sequencing of the output enable.
 * assumes vin_meas_i, unit_cycles_i and the clear and fault strobes
 * come from logic on clock_i; on_cmd_i and the bus pins are async.
 */
`timescale 1ns/1ps
`include "ivf_defines.vh"

// Notes on behaviour
// - sixteen bit threshold register, word access, linear
// - action byte register, byte access
// - response 00: keep regulating through the fault
// - response 01: run for delay, then retry
// - response 10: disable output at once, then retry
// - response 11: stay off until fault cleared
// - retry 000: never restart, stay off
// - retry 1..6: that many attempts, then off
// - attempts spaced by delay count times unit
// - retry 111: retry forever until off or fault
// - delay field counts two to the field units
// - time unit length comes from separate register
module ivf_fault_top #(
	parameter [6:0] SMB_ADDR = `IVF_SMB_ADDR,
	parameter       UNIT_W   = 24
) (
	// clock and reset
	input  wire              clock_i,
	input  wire              srst_i,
	// management bus pins
	input  wire              scl_i,
	input  wire              sda_i,
	output wire              sda_o,
	output wire              sda_oe_n_o,
	// measurement and configuration
	input  wire [15:0]       vin_meas_i,
	input  wire [UNIT_W-1:0] unit_cycles_i,
	// commands and other faults
	input  wire              on_cmd_i,
	input  wire              other_fault_i,
	input  wire              status_clear_i,
	input  wire              clear_faults_i,
	// results
	output reg               output_enable_o,
	output reg               fault_status_o,
	output reg               fault_active_o,
	output reg               latched_off_o
);

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	localparam [2:0] ST_RUN    = 3'd0;  // output on, no action pending
	localparam [2:0] ST_DELAY  = 3'd1;  // output on, delay running
	localparam [2:0] ST_SPACE  = 3'd2;  // output off, waiting to retry
	localparam [2:0] ST_LATCH  = 3'd3;  // output off until cleared
	localparam [2:0] ST_CMDOFF = 3'd4;  // commanded off

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// linear word to fixed point scaled by two to the sixteenth;
	// flipping the exponent sign bit adds the bias of sixteen
	function signed [47:0] ivf_lin;
		input [15:0] w;
		reg signed [47:0] m;
		reg [4:0] sh;
		begin
			m = {{37{w[`IVF_LIN_MHI]}}, w[`IVF_LIN_MHI:`IVF_LIN_MLO]};
			sh = {~w[`IVF_LIN_ESGN], w[`IVF_LIN_EHI:`IVF_LIN_ELO]};
			ivf_lin = m <<< sh;
		end
	endfunction

	// delay field to unit count, one to one hundred twenty eight
	function [7:0] ivf_pow2;
		input [2:0] code;
		begin
			ivf_pow2 = 8'h01 << code;
		end
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	reg  [15:0]       thr;        // fault threshold word
	reg  [7:0]        act;        // action byte
	reg  [7:0]        cmd;        // last command code
	reg  [7:0]        lo_byte;    // low byte of a word write
	reg  [3:0]        wr_idx;     // data byte index after command
	reg  [2:0]        state;      // sequencer state
	reg  [2:0]        tries;      // attempts still allowed
	reg  [7:0]        units;      // time units left in timer
	reg  [UNIT_W-1:0] cyc;        // cycles into current unit
	reg               on_m;       // on command sync stage one
	reg               on_s;       // on command sync stage two
	reg  [7:0]        tx_data;    // read data for the slave
	wire              rx_valid;
	wire              rx_first;
	wire [7:0]        rx_data;
	wire [3:0]        tx_idx;
	wire [1:0]        rsp;
	wire [2:0]        rty;
	wire [2:0]        dly;
	wire              fault_now;
	wire              clr;
	wire [UNIT_W-1:0] last_cyc;
	wire              tdone;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	ivf_smb_slave #(
		.ADDR       (SMB_ADDR)
	) u_slave (
		.clock_i    (clock_i),
		.srst_i     (srst_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.sda_o      (sda_o),
		.sda_oe_n_o (sda_oe_n_o),
		.rx_valid_o (rx_valid),
		.rx_first_o (rx_first),
		.rx_data_o  (rx_data),
		.tx_idx_o   (tx_idx),
		.tx_data_i  (tx_data)
	);

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// word data arrives low byte first; the word lands only when
	// the high byte does, so a short write leaves the old value
	always @(posedge clock_i) begin
		if (srst_i) begin
			thr     <= `IVF_THR_RST;
			act     <= `IVF_ACT_RST;
			cmd     <= 8'h00;
			lo_byte <= 8'h00;
			wr_idx  <= 4'd0;
		end else if (rx_valid) begin
			if (rx_first) begin
				// command byte opens a new transfer
				cmd    <= rx_data;
				wr_idx <= 4'd0;
			end else begin
				wr_idx <= (wr_idx == 4'hf) ? wr_idx : wr_idx + 4'd1;
				if (cmd == `IVF_CMD_THR) begin
					if (wr_idx == 4'd0) begin
						lo_byte <= rx_data;
					end else if (wr_idx == 4'd1) begin
						thr <= {rx_data, lo_byte};
					end
				end else if (cmd == `IVF_CMD_ACT) begin
					if (wr_idx == 4'd0) begin
						act <= rx_data;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// unknown codes read as all ones, like a released line
	always @* begin
		if (cmd == `IVF_CMD_THR) begin
			tx_data = (tx_idx == 4'd0) ? thr[7:0] : thr[15:8];
		end else if (cmd == `IVF_CMD_ACT) begin
			tx_data = act;
		end else begin
			tx_data = `IVF_RD_NONE;
		end
	end

	// ----------------------------------------------------------------
	// field decode and fault detect
	// ----------------------------------------------------------------
	assign rsp = act[`IVF_RSP_HI:`IVF_RSP_LO];
	assign rty = act[`IVF_RTY_HI:`IVF_RTY_LO];
	assign dly = act[`IVF_DLY_HI:`IVF_DLY_LO];

	// signed compare after normalising both linear words
	assign fault_now = ivf_lin(vin_meas_i) > ivf_lin(thr);

	// any of the software clears
	assign clr = status_clear_i | clear_faults_i;

	// ----------------------------------------------------------------
	// on command synchroniser
	// ----------------------------------------------------------------
	// pin level, so two flops before anything reads it
	always @(posedge clock_i) begin
		if (srst_i) begin
			on_m <= 1'b0;
			on_s <= 1'b0;
		end else begin
			on_m <= on_cmd_i;
			on_s <= on_m;
		end
	end

	// ----------------------------------------------------------------
	// delay timer
	// ----------------------------------------------------------------
	// a zero unit length is treated as one cycle per unit
	assign last_cyc = (unit_cycles_i == {UNIT_W{1'b0}}) ?
		{UNIT_W{1'b0}} : unit_cycles_i - {{(UNIT_W-1){1'b0}}, 1'b1};
	assign tdone = (units == 8'd1) && (cyc >= last_cyc);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// off command and other faults override every state; the
	// timer counts first and a state may reload it below
	always @(posedge clock_i) begin
		if (srst_i) begin
			state <= ST_CMDOFF;
			tries <= 3'd0;
			units <= 8'd0;
			cyc   <= {UNIT_W{1'b0}};
		end else begin
			// timer runs whenever units remain
			if (units != 8'd0) begin
				if (cyc >= last_cyc) begin
					cyc   <= {UNIT_W{1'b0}};
					units <= units - 8'd1;
				end else begin
					cyc <= cyc + {{(UNIT_W-1){1'b0}}, 1'b1};
				end
			end
			if (!on_s) begin
				// off ends any retry loop; on again clears
				state <= ST_CMDOFF;
				units <= 8'd0;
			end else if (other_fault_i) begin
				state <= ST_LATCH;
				units <= 8'd0;
			end else begin
				case (state)
					ST_RUN: begin
						if (fault_now) begin
							case (rsp)
								`IVF_RSP_IGNORE: state <= ST_RUN;
								`IVF_RSP_CONT: begin
									units <= ivf_pow2(dly);
									cyc   <= {UNIT_W{1'b0}};
									state <= ST_DELAY;
								end
								`IVF_RSP_DISR: begin
									// shut down now, retry policy next
									if (rty == `IVF_RTY_NONE) begin
										state <= ST_LATCH;
									end else begin
										tries <= rty;
										units <= ivf_pow2(dly);
										cyc   <= {UNIT_W{1'b0}};
										state <= ST_SPACE;
									end
								end
								default: state <= ST_LATCH;
							endcase
						end
					end
					ST_DELAY: begin
						if (!fault_now) begin
							// fault went away while running
							state <= ST_RUN;
							units <= 8'd0;
						end else if (tdone) begin
							if (rty == `IVF_RTY_NONE) begin
								state <= ST_LATCH;
							end else begin
								tries <= rty;
								units <= ivf_pow2(dly);
								cyc   <= {UNIT_W{1'b0}};
								state <= ST_SPACE;
							end
						end
					end
					ST_SPACE: begin
						if (tdone) begin
							if (!fault_now) begin
								// restart attempt succeeds
								state <= ST_RUN;
							end else if ((rty == `IVF_RTY_FOREVER) || (tries > 3'd1)) begin
								// attempt failed, space the next one
								if (rty != `IVF_RTY_FOREVER) begin
									tries <= tries - 3'd1;
								end
								units <= ivf_pow2(dly);
								cyc   <= {UNIT_W{1'b0}};
							end else begin
								state <= ST_LATCH;
							end
						end
					end
					ST_LATCH: begin
						if (clr) begin
							state <= ST_RUN;
						end
					end
					ST_CMDOFF: state <= ST_RUN;
					default:   state <= ST_LATCH;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// status bit: a fault in the clear cycle still sets it
	always @(posedge clock_i) begin
		if (srst_i) begin
			output_enable_o <= 1'b0;
			fault_status_o  <= 1'b0;
			fault_active_o  <= 1'b0;
			latched_off_o   <= 1'b0;
		end else begin
			output_enable_o <= on_s & ((state == ST_RUN) | (state == ST_DELAY));
			fault_status_o  <= fault_now | (fault_status_o & ~clr);
			fault_active_o  <= fault_now;
			latched_off_o   <= (state == ST_LATCH);
		end
	end

endmodule

//--- ivf_fault_top_properties.sv
/* port assertions for the input over-voltage fault block.
   assumes one clock domain, clock_i, with synchronous srst_i. */
`timescale 1ns/1ps
module ivf_fault_props (
	// clock and reset
	input wire clock_i,
	input wire srst_i,
	// commands
	input wire on_cmd_i,
	input wire other_fault_i,
	input wire status_clear_i,
	input wire clear_faults_i,
	// results
	input wire sda_oe_n_o,
	input wire output_enable_o,
	input wire fault_status_o,
	input wire fault_active_o,
	input wire latched_off_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	// five edges cover the two sync flops plus state and output flops
	sequence on_held;
		on_cmd_i [*5];
	endsequence
	sequence off_held;
		!on_cmd_i [*5];
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	reset_quiet_a: assert property ($fell(srst_i) |-> !output_enable_o && !latched_off_o && sda_oe_n_o)
		else $error("outputs not quiet after reset");
	latch_dark_a: assert property (latched_off_o |-> !output_enable_o)
		else $error("output on while latched off");
	latch_hold_a: assert property (on_held ##0 (latched_off_o && !status_clear_i && !clear_faults_i
		&& !$past(status_clear_i) && !$past(clear_faults_i)) |=> latched_off_o)
		else $error("latch dropped without a clear");
	latch_clear_a: assert property (latched_off_o && on_cmd_i && (status_clear_i || clear_faults_i)
		|-> ##[1:3] !latched_off_o)
		else $error("clear did not release latch");
	off_cmd_a: assert property (off_held |-> !output_enable_o)
		else $error("output on while commanded off");
	turn_on_a: assert property ($rose(output_enable_o) |-> $past(on_cmd_i, 3))
		else $error("output rose without on command");
	other_fault_a: assert property (other_fault_i && output_enable_o |-> ##[1:3] !output_enable_o)
		else $error("other fault did not shut output");
	status_set_a: assert property ($rose(fault_active_o) |-> ##[0:2] fault_status_o)
		else $error("status bit not set on fault");
endmodule

bind ivf_fault_top ivf_fault_props props (
	.clock_i(clock_i), .srst_i(srst_i), .on_cmd_i(on_cmd_i), .other_fault_i(other_fault_i),
	.status_clear_i(status_clear_i), .clear_faults_i(clear_faults_i), .sda_oe_n_o(sda_oe_n_o),
	.output_enable_o(output_enable_o), .fault_status_o(fault_status_o),
	.fault_active_o(fault_active_o), .latched_off_o(latched_off_o));

//--- ivf_smb_host.sv
/* bus host model: drives scl and its side of open-drain sda, 80 ns bus clock.
   assumes sda_i is the wired level of a pulled-up line. */
`timescale 1ns/1ps
module ivf_smb_host (
	// bus pins
	output logic scl_o,
	output logic sda_o,
	input  wire  sda_i
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// data moves only while scl is low; sampled midway through the high phase
	task bit_x(input logic b, output logic r);
		#20 sda_o = b;
		#20 scl_o = 1'b1;
		#20 r = sda_i;
		#20 scl_o = 1'b0;
	endtask
	// release sda first so a late device ack cannot look like a stop
	task start_c;
		#20 sda_o = 1'b1;
		#20 scl_o = 1'b1;
		#20 sda_o = 1'b0;
		#20 scl_o = 1'b0;
	endtask
	task stop_c;
		#20 sda_o = 1'b0;
		#20 scl_o = 1'b1;
		#20 sda_o = 1'b1;
		#20;
	endtask
	task send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask
	// last byte of a read is answered with a nack
	task recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(last, r);
	endtask
	task head(input logic [6:0] a, input logic [7:0] c, output logic ok);
		logic k1, k2;
		start_c();
		send({a, 1'b0}, k1);
		send(c, k2);
		ok = k1 & k2;
	endtask
	task write_byte(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
		logic k;
		head(a, c, ok);
		send(d, k);
		stop_c();
		ok = ok & k;
	endtask
	// word order: low byte, then high byte
	task write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, output logic ok);
		logic k1, k2;
		head(a, c, ok);
		send(d[7:0], k1);
		send(d[15:8], k2);
		stop_c();
		ok = ok & k1 & k2;
	endtask
	task read_byte(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d, output logic ok);
		logic k;
		head(a, c, ok);
		start_c();
		send({a, 1'b1}, k);
		recv(1'b1, d);
		stop_c();
		ok = ok & k;
	endtask
	task read_word(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d, output logic ok);
		logic k;
		head(a, c, ok);
		start_c();
		send({a, 1'b1}, k);
		recv(1'b0, d[7:0]);
		recv(1'b1, d[15:8]);
		stop_c();
		ok = ok & k;
	endtask
endmodule

//--- ivf_fault_top_bench.sv
/* testbench for the input over-voltage fault block: registers over the bus,
   then each response and retry mode. assumes host model and checker compiled. */
`timescale 1ns/1ps
`include "ivf_defines.vh"
module ivf_fault_top_bench;
	logic        clock_i        = 1'b0;
	logic        srst_i         = 1'b1;
	logic        on_cmd_i       = 1'b0;
	logic        other_fault_i  = 1'b0;
	logic        status_clear_i = 1'b0;
	logic        clear_faults_i = 1'b0;
	logic [15:0] vin_meas_i     = 16'h0000;
	logic [23:0] unit_cycles_i  = 24'h000004;
	wire         scl, sda_host, sda_o, sda_oe_n_o, sda_wire;
	wire         output_enable_o, fault_status_o, fault_active_o, latched_off_o;
	int          n_mismatch     = 0;
	int          total_checks   = 0;
	int          c;
	logic        ok;
	logic [15:0] rd;
	logic [7:0]  rb;
	// threshold 100 at exponent 0; lo equals it at exponent 1, hi just exceeds
	localparam logic [15:0] THR = 16'h0064;
	localparam logic [15:0] LO  = 16'h0832;
	localparam logic [15:0] HI  = 16'h0833;
	localparam logic [6:0]  ADR = `IVF_SMB_ADDR;
	// wired-and with pull-up
	assign sda_wire = sda_host & (sda_oe_n_o | sda_o);
	always #4 clock_i = ~clock_i;
	ivf_smb_host host (.scl_o(scl), .sda_o(sda_host), .sda_i(sda_wire));
	ivf_fault_top #(.UNIT_W(24)) dut (
		.clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .vin_meas_i(vin_meas_i), .unit_cycles_i(unit_cycles_i),
		.on_cmd_i(on_cmd_i), .other_fault_i(other_fault_i), .status_clear_i(status_clear_i),
		.clear_faults_i(clear_faults_i), .output_enable_o(output_enable_o),
		.fault_status_o(fault_status_o), .fault_active_o(fault_active_o), .latched_off_o(latched_off_o));
	// inputs change 1 ns after the edge
	task step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task inr(input string nm, input int v, input int lo, input int hi);
		chk(nm, 16'(v >= lo && v <= hi), 16'h0001);
	endtask
	// cycles until enable (s=0) or latch flag (s=1) reaches v, capped
	task wait_for(input int s, input logic v, output int n);
		n = 0;
		while ((s ? latched_off_o : output_enable_o) !== v && n < 2000) begin
			step(1);
			n++;
		end
	endtask
	// program action, clear, see output up, then raise input above threshold
	task arm(input logic [7:0] a);
		host.write_byte(ADR, `IVF_CMD_ACT, a, ok);
		step(1);
		vin_meas_i = LO;
		clear_faults_i = 1'b1;
		step(1);
		clear_faults_i = 1'b0;
		wait_for(0, 1'b1, c);
		chk("run_up", output_enable_o, 1'b1);
		chk("sts_clr", fault_status_o, 1'b0);
		vin_meas_i = HI;
	endtask
	task test_done;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		test_done();
	end
	initial begin
		step(20);
		srst_i = 1'b0;
		step(2);
		host.read_word(ADR, `IVF_CMD_THR, rd, ok);
		chk("thr_rst", rd, `IVF_THR_RST);
		host.read_byte(ADR, `IVF_CMD_ACT, rb, ok);
		chk("act_rst", rb, `IVF_ACT_RST);
		host.write_word(ADR, `IVF_CMD_THR, THR, ok);
		host.read_word(ADR, `IVF_CMD_THR, rd, ok);
		chk("thr_rw", rd, THR);
		host.write_byte(ADR, `IVF_CMD_ACT, 8'h5a, ok);
		host.read_byte(ADR, `IVF_CMD_ACT, rb, ok);
		chk("act_rw", rb, 8'h5a);
		host.write_byte(ADR, 8'h57, 8'h00, ok);
		chk("unk_ack", ok, 1'b1);
		host.read_byte(ADR, 8'h57, rb, ok);
		chk("unk_rd", rb, `IVF_RD_NONE);
		host.write_byte(ADR + 7'h01, `IVF_CMD_ACT, 8'h00, ok);
		chk("adr_nak", ok, 1'b0);
		host.read_byte(ADR, `IVF_CMD_ACT, rb, ok);
		chk("act_kept", rb, 8'h5a);
		step(1);
		on_cmd_i = 1'b1;
		// ignore: keeps running, status still reported; another fault still trips
		arm(8'h00);
		step(40);
		chk("ign_run", output_enable_o, 1'b1);
		chk("ign_flt", fault_active_o, 1'b1);
		chk("ign_sts", fault_status_o, 1'b1);
		other_fault_i = 1'b1;
		step(3);
		other_fault_i = 1'b0;
		step(2);
		chk("oth_lat", latched_off_o, 1'b1);
		// latch until cleared, by status clear and by off-then-on
		arm(8'hc0);
		wait_for(0, 1'b0, c);
		inr("lat_off", c, 1, 3);
		vin_meas_i = LO;
		step(20);
		chk("lat_hold", output_enable_o, 1'b0);
		chk("lat_flag", latched_off_o, 1'b1);
		status_clear_i = 1'b1;
		step(1);
		status_clear_i = 1'b0;
		wait_for(0, 1'b1, c);
		inr("lat_clr", c, 1, 6);
		vin_meas_i = HI;
		wait_for(1, 1'b1, c);
		vin_meas_i = LO;
		on_cmd_i = 1'b0;
		step(8);
		on_cmd_i = 1'b1;
		wait_for(0, 1'b1, c);
		inr("lat_cyc", c, 3, 6);
		// keep running for four units of four cycles, then latch with no retry
		arm(8'h42);
		wait_for(0, 1'b0, c);
		inr("cont_dly", c, 16, 20);
		step(2);
		chk("cont_lat", latched_off_o, 1'b1);
		// run for two units, then one attempt a further two units on, then latch
		arm(8'h49);
		wait_for(0, 1'b0, c);
		inr("cont_rty", c, 8, 12);
		wait_for(1, 1'b1, c);
		inr("cont_att", c, 8, 11);
		// fault gone inside a long delay: output never drops
		arm(8'h47);
		step(20);
		vin_meas_i = LO;
		step(600);
		chk("cont_end", output_enable_o, 1'b1);
		chk("cont_nolat", latched_off_o, 1'b0);
		// n failed attempts, one unit apart, before the latch
		for (int n = 1; n <= 6; n++) begin
			arm({2'b10, 3'(n), 3'b000});
			wait_for(0, 1'b0, c);
			inr("dis_now", c, 1, 3);
			wait_for(1, 1'b1, c);
			inr("rty_cnt", c, 4 * n, 4 * n + 3);
		end
		// attempt spacing follows delay code and unit length
		for (int d = 0; d < 4; d++) begin
			unit_cycles_i = 24'(3 + d);
			arm({5'b10001, 3'(d)});
			wait_for(0, 1'b0, c);
			vin_meas_i = LO;
			wait_for(0, 1'b1, c);
			inr("rty_gap", c, (3 + d) << d, ((3 + d) << d) + 3);
		end
		unit_cycles_i = 24'h000004;
		// endless retry never latches
		arm(8'hb8);
		step(100);
		chk("fvr_nolat", latched_off_o, 1'b0);
		chk("fvr_off", output_enable_o, 1'b0);
		vin_meas_i = LO;
		wait_for(0, 1'b1, c);
		inr("fvr_up", c, 1, 8);
		test_done();
	end
endmodule
